// [core/aux_fan_speed_controller.sv]
// The APB slave port was left to the implementer.
`timescale 1ns/10ps
module aux_fan_speed_controller
  import aux_fan_pkg::*;
#(
  parameter int tick_len = tick_cycles
)
(
  // Clock, reset, enable
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // Sensor side
  input  wire temp_bundle_s temps,
  input  wire curve_s       curve,
  input  wire logic [11:0]  tach_count,
  input  wire logic [7:0]   default_speed,
  // Fan drive
  output logic              aux_fan_drive_output
);

  // Reset synchroniser
  logic       rst_meta;
  logic       rst_n;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Registers
  logic [7:0] source_select_and_floor_enable;
  logic [7:0] target_temp_or_speed_low;
  logic [7:0] mode_and_tolerance;
  logic [7:0] step_up_interval;
  logic [7:0] step_down_interval;
  logic [7:0] minimum_drive_value;
  logic [7:0] startup_drive_value;
  logic [7:0] fall_to_zero_time;
  logic [7:0] drive_duty_value;
  logic [7:0] tolerance_and_speed_high;

  // Control state
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_run   = 4'b0010,
    st_fall  = 4'b0100,
    st_start = 4'b1000
  } ctl_e;
  ctl_e       ctl;
  logic       loaded;        // Default speed taken once after reset
  logic [27:0] tick_cnt;     // Divider for 0.1 s ticks
  logic       tick;          // One pulse each 0.1 s
  logic [7:0] up_cnt;        // Ticks since the step-up interval last ran out
  logic [7:0] dn_cnt;        // Ticks since the step-down interval last ran out
  logic [7:0] fall_cnt;      // Ticks spent falling to zero
  logic [7:0] pwm_cnt;       // PWM period counter
  logic [7:0] duty_now;      // Duty in force for the running period

  // Access decode
  logic       wr_acc;
  logic       rd_acc;
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && !penable && !pwrite;

  // Register index of a byte address: one word per register, so the two
  // low address bits are ignored and bits 11:10 alias onto the same map
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    return a[9:2];
  endfunction

  // Field views
  logic [3:0]  mode;
  logic [4:0]  src;
  logic [5:0]  tol;
  logic [11:0] tach_target;
  assign mode        = mode_and_tolerance[7:4];
  assign src         = source_select_and_floor_enable[4:0];
  assign tol         = {tolerance_and_speed_high[6:4], mode_and_tolerance[2:0]};
  assign tach_target = {tolerance_and_speed_high[3:0], target_temp_or_speed_low};

  // Temperature source mux
  function automatic logic [7:0] pick_temp(input logic [4:0] s, input temp_bundle_s t);
    logic [7:0] r;
    r = 8'h00;
    if (s == src_sys)
      r = t.sys;
    else if (s == src_proc)
      r = t.proc_t;
    else if (s > src_proc && s <= src_aux_last)
      r = t.aux[2'(s - 5'h03)];
    else if (s >= src_host0 && s < src_agent0)
      r = t.host[3'(s - src_host0)];
    else if (s >= src_agent0 && s < src_hub0)
      r = t.agent[1'(s - src_agent0)];
    else if (s >= src_hub0 && s < src_byte)
      r = t.hub[3'(s - src_hub0)];
    else if (s == src_byte)
      r = t.byte_t;
    else if (s == src_synth)
      r = t.synth;
    return r;
  endfunction

  // Four-point curve lookup
  function automatic logic [7:0] curve_duty(input logic [7:0] t, input curve_s c);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++)
      if (t >= c.temp[i])
        r = c.duty[i];
    return r;
  endfunction

  logic [7:0] temp_now;
  logic [7:0] curve_target;
  logic       too_hot;
  logic       too_cold;
  logic       too_slow;
  logic       too_fast;
  logic [7:0] floor_val;
  assign temp_now     = pick_temp(src, temps);
  assign curve_target = curve_duty(temp_now, curve);
  assign too_hot  = {1'b0, temp_now} > ({1'b0, target_temp_or_speed_low} + {3'b000, tol});
  assign too_cold = {1'b0, temp_now} + {3'b000, tol} < {1'b0, target_temp_or_speed_low};
  // Tach count rises as the fan slows
  assign too_slow = {1'b0, tach_count} > ({1'b0, tach_target} + 13'(tol));
  assign too_fast = {1'b0, tach_count} + 13'(tol) < {1'b0, tach_target};
  assign floor_val = source_select_and_floor_enable[floor_bit] ? minimum_drive_value : 8'h00;

  // Step requests
  logic want_up;
  logic want_dn;
  always_comb
  begin
    want_up = 1'b0;
    want_dn = 1'b0;
    case (mode)
      mode_hold:
      begin
        want_up = too_hot;
        want_dn = too_cold && drive_duty_value > floor_val;
      end
      mode_speed:
      begin
        want_up = too_slow;
        want_dn = too_fast;
      end
      mode_curve:
      begin
        want_up = drive_duty_value < curve_target;
        want_dn = drive_duty_value > curve_target;
      end
      default:
      begin
        want_up = 1'b0;
        want_dn = 1'b0;
      end
    endcase
  end

  logic up_due;
  logic dn_due;
  assign up_due = tick && (up_cnt + 8'h01 >= step_up_interval);
  assign dn_due = tick && (dn_cnt + 8'h01 >= step_down_interval);

  // 0.1 s tick generator
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt <= 28'h0000000;
      tick     <= 1'b0;
    end
    else if (clk_en)
    begin
      tick <= (tick_cnt == 28'(tick_len - 1));
      if (tick_cnt == 28'(tick_len - 1))
        tick_cnt <= 28'h0000000;
      else
        tick_cnt <= tick_cnt + 28'h0000001;
    end
  end

  // Interval counters
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_cnt <= 8'h00;
      dn_cnt <= 8'h00;
    end
    else if (clk_en && tick)
    begin
      up_cnt <= up_due ? 8'h00 : up_cnt + 8'h01;
      dn_cnt <= dn_due ? 8'h00 : dn_cnt + 8'h01;
    end
  end

  // Register writes
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      source_select_and_floor_enable <= rst_source;
      target_temp_or_speed_low       <= rst_target;
      mode_and_tolerance             <= rst_mode;
      step_up_interval               <= rst_step;
      step_down_interval             <= rst_step;
      minimum_drive_value            <= rst_min_val;
      startup_drive_value            <= rst_start;
      fall_to_zero_time              <= rst_stop_tm;
      tolerance_and_speed_high       <= rst_tol_high;
    end
    else if (clk_en && wr_acc)
    begin
      // Writes land at the edge where the access phase meets ready
      case (reg_index(paddr))
        off_source:   source_select_and_floor_enable <= pwdata[7:0] & mask_source;
        off_target:   target_temp_or_speed_low       <= pwdata[7:0];
        off_mode:     mode_and_tolerance             <= pwdata[7:0] & mask_mode;
        off_step_up:  step_up_interval               <= pwdata[7:0];
        off_step_dn:  step_down_interval             <= pwdata[7:0];
        off_min_val:  minimum_drive_value            <= pwdata[7:0];
        off_start:    startup_drive_value            <= pwdata[7:0];
        off_stop_tm:  fall_to_zero_time              <= pwdata[7:0];
        off_tol_high: tolerance_and_speed_high       <= pwdata[7:0] & mask_tol_high;
        default:      ;
      endcase
    end
  end

  // Drive value and automatic control
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_duty_value <= rst_duty;
      loaded           <= 1'b0;
      ctl              <= st_idle;
      fall_cnt         <= 8'h00;
    end
    else if (clk_en)
    begin
      if (!loaded)
      begin
        drive_duty_value <= default_speed;
        loaded           <= 1'b1;
      end
      else if (mode == mode_manual)
      begin
        ctl <= st_idle;
        if (wr_acc && reg_index(paddr) == off_duty)
          drive_duty_value <= pwdata[7:0];
      end
      else
      begin
        case (ctl)
          st_idle:
            ctl <= st_run;
          st_run:
          begin
            if (mode == mode_hold && drive_duty_value == 8'h00 && want_up && up_due)
            begin
              drive_duty_value <= startup_drive_value;
              ctl              <= st_start;
            end
            else if (mode == mode_hold && want_dn && !source_select_and_floor_enable[floor_bit]
                     && drive_duty_value <= minimum_drive_value)
            begin
              fall_cnt <= 8'h00;
              ctl      <= st_fall;
            end
            else if (want_up && up_due && drive_duty_value != 8'hff)
              drive_duty_value <= drive_duty_value + 8'h01;
            else if (want_dn && dn_due && drive_duty_value != 8'h00)
              drive_duty_value <= drive_duty_value - 8'h01;
          end
          st_fall:
          begin
            if (!(too_cold && mode == mode_hold))
              ctl <= st_run;
            else if (tick)
            begin
              fall_cnt <= fall_cnt + 8'h01;
              if (fall_cnt + 8'h01 >= fall_to_zero_time)
              begin
                drive_duty_value <= 8'h00;
                ctl              <= st_run;
              end
            end
          end
          st_start:
            ctl <= st_run;
          default:
            ctl <= st_idle;
        endcase
      end
    end
  end

  // Last count of a PWM period
  localparam logic [7:0] pwm_last = 8'(pwm_period - 1);

  // PWM generator, duty over 255; the duty is taken only at the period boundary
  // so that a write or a step never cuts a period short or adds a stray pulse
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwm_cnt              <= 8'h00;
      duty_now             <= 8'h00;
      aux_fan_drive_output <= 1'b0;
    end
    else if (clk_en)
    begin
      pwm_cnt              <= (pwm_cnt == pwm_last) ? 8'h00 : pwm_cnt + 8'h01;
      aux_fan_drive_output <= pwm_cnt < duty_now;
      if (pwm_cnt == pwm_last)
        duty_now <= drive_duty_value;               // Next period runs on the new value
    end
  end

  // APB answer: no wait state, data set up in setup phase
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (rd_acc)
      begin
        // Read data is captured in the setup phase and stands through the access
        case (reg_index(paddr))
          off_source:   prdata <= {24'h000000, source_select_and_floor_enable};
          off_target:   prdata <= {24'h000000, target_temp_or_speed_low};
          off_mode:     prdata <= {24'h000000, mode_and_tolerance};
          off_step_up:  prdata <= {24'h000000, step_up_interval};
          off_step_dn:  prdata <= {24'h000000, step_down_interval};
          off_min_val:  prdata <= {24'h000000, minimum_drive_value};
          off_start:    prdata <= {24'h000000, startup_drive_value};
          off_stop_tm:  prdata <= {24'h000000, fall_to_zero_time};
          off_duty:     prdata <= {24'h000000, drive_duty_value};
          off_tol_high: prdata <= {24'h000000, tolerance_and_speed_high};
          off_status:   prdata <= {20'h00000, ctl, temp_now};
          default:      prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// [core/aux_fan_pkg.sv]
// Behaviour
// - Low source codes pick local temperature inputs
// - Codes 08-0F host readings, 10-11 agents
// - Codes 12-19 hub, 1A byte, 1F synthetic
// - Floor bit stops hold mode stepping below minimum
// - Mode field selects manual, hold, speed, curve
// - Target is temperature or 12-bit tach count
// - Six-bit tolerance band around target value
// - Step up once per interval of 0.1 s units
// - Step down once per interval of 0.1 s units
// - Cold temperature decreases drive to minimum value
// - Start from zero in hold mode jumps to start-up value
// - Minimum to zero fall over stop time
// - Duty equals drive value over 255
// - Initial drive loaded from default speed input
// - High register holds tolerance high and target high
package aux_fan_pkg;

  // Register indices; each register is one word, so its byte address is four times the index
  localparam logic [7:0] off_source   = 8'h00;
  localparam logic [7:0] off_target   = 8'h01;
  localparam logic [7:0] off_mode     = 8'h02;
  localparam logic [7:0] off_step_up  = 8'h03;
  localparam logic [7:0] off_step_dn  = 8'h04;
  localparam logic [7:0] off_min_val  = 8'h05;
  localparam logic [7:0] off_start    = 8'h06;
  localparam logic [7:0] off_stop_tm  = 8'h07;
  localparam logic [7:0] off_duty     = 8'h09;
  localparam logic [7:0] off_tol_high = 8'h0c;
  localparam logic [7:0] off_status   = 8'h10;

  // Reset values
  localparam logic [7:0] rst_source   = 8'h03;
  localparam logic [7:0] rst_target   = 8'h00;
  localparam logic [7:0] rst_mode     = 8'h00;
  localparam logic [7:0] rst_step     = 8'h0a;
  localparam logic [7:0] rst_min_val  = 8'h01;
  localparam logic [7:0] rst_start    = 8'h01;
  localparam logic [7:0] rst_stop_tm  = 8'h3c;
  localparam logic [7:0] rst_tol_high = 8'h00;
  localparam logic [7:0] rst_duty     = 8'hff;

  // Writable bit masks
  localparam logic [7:0] mask_source   = 8'h9f;
  localparam logic [7:0] mask_mode     = 8'hf7;
  localparam logic [7:0] mask_tol_high = 8'h7f;

  // Field positions
  localparam int floor_bit = 7;

  // Mode codes
  localparam logic [3:0] mode_manual = 4'h0;
  localparam logic [3:0] mode_hold   = 4'h1;
  localparam logic [3:0] mode_speed  = 4'h2;
  localparam logic [3:0] mode_curve  = 4'h4;

  // Source codes
  localparam logic [4:0] src_sys      = 5'h01;
  localparam logic [4:0] src_proc     = 5'h02;
  localparam logic [4:0] src_aux_last = 5'h06;
  localparam logic [4:0] src_host0    = 5'h08;
  localparam logic [4:0] src_agent0   = 5'h10;
  localparam logic [4:0] src_hub0     = 5'h12;
  localparam logic [4:0] src_byte     = 5'h1a;
  localparam logic [4:0] src_synth    = 5'h1f;

  // Timing
  localparam int clk_mhz       = 250;
  localparam int tick_ms       = 100;
  localparam int tick_cycles   = tick_ms * 1000 * clk_mhz;
  localparam int pwm_period    = 255;

  // Temperature inputs travelling together
  typedef struct packed {
    logic [7:0]      sys;
    logic [7:0]      proc_t;
    logic [3:0][7:0] aux;
    logic [7:0][7:0] host;
    logic [1:0][7:0] agent;
    logic [7:0][7:0] hub;
    logic [7:0]      byte_t;
    logic [7:0]      synth;
  } temp_bundle_s;

  // Curve points for the four-point mode
  typedef struct packed {
    logic [3:0][7:0] temp;
    logic [3:0][7:0] duty;
  } curve_s;

endpackage

// [verif/aux_fan_chk.sv]
`timescale 1ns/10ps
module aux_fan_chk
  import aux_fan_pkg::*;
(
  // Clock and reset
  input wire logic        sys_clk,
  input wire logic        nrst,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Fan drive
  input wire logic        aux_fan_drive_output
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [9:0] gap;  // Cycles since the last PWM rise
  logic       seen; // A rise was seen
  logic       prev; // Drive one cycle ago
  // PWM rises come only on period boundaries
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      gap  <= 10'h0;
      seen <= 1'b0;
      prev <= 1'b0;
    end
    else if (clk_en)
    begin
      prev <= aux_fan_drive_output;
      seen <= seen | (aux_fan_drive_output & ~prev);
      gap  <= (aux_fan_drive_output & ~prev) ? 10'h1 : ((gap == 10'h3fc) ? gap : gap + 10'h1);
    end
  AST_SETUP_ANSWER: assert property (psel && !penable && clk_en |=> pready)
    else $error("no answer after setup");
  AST_READY_PULSE: assert property (pready && clk_en |=> !pready)
    else $error("ready held too long");
  AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  AST_READY_CAUSE: assert property ($rose(pready) |-> $past(psel) && !$past(penable))
    else $error("ready without setup");
  AST_NO_ERROR: assert property (pslverr == 1'b0)
    else $error("slave error raised");
  AST_UPPER_ZERO: assert property (prdata[31:12] == 20'h0 && $onehot0(prdata[11:8]))
    else $error("upper read bits set");
  AST_READ_HOLD: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  AST_RESET_QUIET: assert property (disable iff (1'b0) !nrst && !$past(nrst) |-> !pready && prdata == 32'h0
    && !aux_fan_drive_output)
    else $error("outputs busy in reset");
  AST_PWM_PERIOD: assert property (aux_fan_drive_output && !prev && seen && clk_en |-> gap % 10'd255 == 10'h0)
    else $error("pwm period wrong");
  cover property (psel && penable && pready && pwrite);
  cover property (psel && penable && pready && !pwrite);
  cover property (aux_fan_drive_output && !prev && seen);
endmodule

// [verif/fan_model.sv]
`timescale 1ns/10ps
module fan_model
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // Drive in, tach count out
  input  wire logic        drive,
  output logic      [11:0] tach_count
);
  logic [7:0] win; // Position in the 255-cycle window
  logic [7:0] hi;  // High cycles in this window
  // More drive, faster fan, smaller count
  always_ff @(posedge sys_clk or negedge nrst)
    if (!nrst)
    begin
      win        <= 8'h0;
      hi         <= 8'h0;
      tach_count <= 12'hfff;
    end
    else if (win == 8'hfe)
    begin
      win        <= 8'h0;
      hi         <= 8'h0;
      tach_count <= 12'hfff - {1'b0, 8'(hi + {7'h0, drive}), 3'h0};
    end
    else
    begin
      win <= win + 8'h1;
      hi  <= hi + {7'h0, drive};
    end
endmodule

// [verif/aux_fan_speed_controller_tb.sv]
`timescale 1ns/10ps
module aux_fan_speed_controller_tb
  import aux_fan_pkg::*;
;
  logic         sys_clk, nrst, clk_en, psel, penable, pwrite, pready, pslverr, fan_out;
  logic [11:0]  paddr, tach;
  logic [31:0]  pwdata, prdata, rq [$];
  temp_bundle_s temps;
  curve_s       curve;
  logic [7:0]   q, hi;
  int           errors, tests_run;
  aux_fan_speed_controller #(.tick_len(10)) aux_fan_speed_controller_inst (.sys_clk(sys_clk), .nrst(nrst),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .temps(temps), .curve(curve), .tach_count(tach),
    .default_speed(8'h40), .aux_fan_drive_output(fan_out));
  fan_model fan_model_inst (.sys_clk(sys_clk), .nrst(nrst), .drive(fan_out), .tach_count(tach));
  task automatic results();
    $display("tests %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic bad(input string m);
    errors++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  // One APB transfer, read byte kept in q
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00}; // Register index, four bytes a step
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    q = prdata[7:0];
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      bad("bus timeout");
      results();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h0);
    tests_run++;
    if (q !== e) bad($sformatf("addr %h got %h exp %h", a, q, e));
  endtask
  // Rows: write flag, address, data, read-back
  task automatic run();
    foreach (rq[i])
    begin
      if (rq[i][24]) apb(1'b1, rq[i][23:16], rq[i][15:8]);
      rd(rq[i][23:16], rq[i][7:0]);
    end
  endtask
  // Read the duty until it leaves a value
  task automatic poll(input logic [7:0] v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, 8'h09, 8'h0);
      n++;
    end
    while (q === v && n < 100);
    if (q === v)
    begin
      bad("poll timeout");
      results();
    end
  endtask
  function automatic logic [7:0] exp_temp(input logic [4:0] c);
    case (c) inside
      5'h01: return 8'h21;
      5'h02: return 8'h22;
      [5'h03:5'h06]: return 8'h2d + {3'h0, c};
      [5'h08:5'h0f]: return 8'h38 + {3'h0, c};
      5'h10, 5'h11: return 8'h40 + {3'h0, c};
      [5'h12:5'h19]: return 8'h4e + {3'h0, c};
      5'h1a: return 8'h70;
      5'h1f: return 8'h71;
      default: return 8'h00;
    endcase
  endfunction
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    clk_en = 1'b1;
    temps = '0;
    curve = '0;
    temps.sys = 8'h21;
    temps.proc_t = 8'h22;
    temps.byte_t = 8'h70;
    temps.synth = 8'h71;
    for (int i = 0; i < 8; i++)
    begin
      temps.host[i] = 8'h40 + 8'(i);
      temps.hub[i] = 8'h60 + 8'(i);
      if (i < 4) temps.aux[i] = 8'h30 + 8'(i);
      if (i < 2) temps.agent[i] = 8'h50 + 8'(i);
    end
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rq = '{32'h3, 32'h10000, 32'h20000, 32'h3000a, 32'h4000a, 32'h50001, 32'h60001, 32'h7003c, 32'h90040,
      32'hc0000, 32'h80000, 32'h100ff9f, 32'h101a5a5, 32'h1020f07, 32'h10cff7f, 32'h1085500, 32'h1205500,
      32'h1021010, 32'h1022020, 32'h1024040, 32'h1020000, 32'h1098080, 32'h1000303};
    run();
    $display("registers done");
    foreach (rq[i])
    begin
      apb(1'b1, 8'h09, rq[i][7:0]);
      repeat (300) @(posedge sys_clk);
      hi = 8'h0;
      repeat (255) @(posedge sys_clk) hi += {7'h0, fan_out};
      tests_run++;
      if (hi !== rq[i][7:0]) bad("duty");
      if (i == 3) break;
    end
    $display("duty done");
    for (int c = 0; c < 32; c++)
    begin
      apb(1'b1, 8'h00, 8'(c));
      rd(8'h10, exp_temp(5'(c)));
    end
    $display("source done");
    temps.aux[0] <= 8'h14;
    // Nonzero minimum and start-up values
    rq = '{32'h1091414, 32'h1051010, 32'h1030101, 32'h1040101, 32'h1070202, 32'h1063030, 32'h1013232,
      32'h10c0000, 32'h1008383, 32'h1021010};
    run();
    repeat (150) @(posedge sys_clk);
    rd(8'h09, 8'h10);
    repeat (200) @(posedge sys_clk);
    rd(8'h09, 8'h10);
    apb(1'b1, 8'h00, 8'h03);
    rd(8'h09, 8'h10);
    repeat (60) @(posedge sys_clk);
    rd(8'h09, 8'h00);
    temps.aux[0] <= 8'h5a;
    poll(8'h00);
    rd(8'h09, 8'h30);
    poll(8'h30);
    rd(8'h09, 8'h31);
    $display("hold done");
    rq = '{32'h1020000, 32'h1095050, 32'h1031e1e, 32'h1041e1e, 32'h101ffff, 32'h10c0c0c, 32'h1022020};
    run();
    repeat (8000) @(posedge sys_clk);
    apb(1'b0, 8'h09, 8'h0);
    tests_run++;
    if ((q >= 8'h5e && q <= 8'h62) !== 1'b1) bad("speed");
    $display("speed done");
    // Curve mode: reading 5a lies past the third point, so the drive settles on its duty
    curve <= {8'h60, 8'h50, 8'h40, 8'h30, 8'h90, 8'h68, 8'h58, 8'h40};
    rq = '{32'h1030101, 32'h1040101, 32'h1024040};
    run();
    repeat (400) @(posedge sys_clk);
    rd(8'h09, 8'h68);
    apb(1'b1, 8'h09, 8'h11);
    rd(8'h09, 8'h68);
    $display("curve done");
    // Clock enable low freezes the pin
    clk_en <= 1'b0;
    @(posedge sys_clk);
    q = {7'h0, fan_out};
    hi = 8'h0;
    repeat (300) @(posedge sys_clk) if (fan_out !== q[0]) hi = 8'h1;
    clk_en <= 1'b1;
    tests_run++;
    if (hi !== 8'h0) bad("enable");
    $display("enable done");
    nrst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(8'h09, 8'h40);
    rd(8'h02, 8'h00);
    $display("reset done");
    results();
  end
endmodule
bind aux_fan_speed_controller aux_fan_chk aux_fan_chk_inst (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .aux_fan_drive_output(aux_fan_drive_output));
